/* tmz_timer0.sv */
// timer/counter with shared 8-bit prescaler, one instruction cycle per four clk phases
//
// What this block does
// - clock source bit low: count once per instruction cycle, prescaler not assigned
// - after a count write, hold counting for two instruction cycles
// - clock source bit high: count edges of the external count pin
// - edge bit low counts rising edges, high counts falling edges
// - prescaler serves timer when assign bit low, watchdog when high
// - prescaler count has no read or write path
// - timer prescale ratios 1:2 through 1:256, powers of two
// - rollover from ff to 00 sets the overflow flag
// - interrupt request only when enable bit set; flag sets regardless
// - flag stays set until software clears it
// - no counting while the processor sleeps
// - readable and writable 8-bit count behind programmable prescaler
// - ratio field plus assign bit sets ratio of assigned unit
// - count write clears prescaler when it serves the timer
// - clear watchdog instruction clears prescaler when it serves watchdog
// - counter mode samples prescaler output on phases two and four
`timescale 1ns/1ns
module tmz_timer0
  import tmz_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       sleep_mode,
  input  wire logic       external_count_pin,
  input  wire logic       option_we,
  input  wire logic [5:0] option_wdata,
  input  wire logic       count_we,
  input  wire logic [7:0] count_wdata,
  input  wire logic       flag_clr,
  input  wire logic       flag_set,
  input  wire logic       int_enable_we,
  input  wire logic       int_enable_wdata,
  input  wire logic       clear_watchdog_instruction,
  input  wire logic       watchdog_tick,
  output logic [7:0]      count_register,
  output logic [5:0]      option_bits,
  output logic            overflow_flag,
  output logic            overflow_int_enable,
  output logic            overflow_irq,
  output logic            watchdog_prescaled_tick
);
  // =====================================================
  // state
  tmz_phase_t phase_q, phase_d;
  logic [1:0] pin_sync_q, pin_sync_d;
  logic       pin_prev_q, pin_prev_d;
  logic [7:0] presc_q, presc_d;
  logic       psout_smp_q, psout_smp_d;
  logic [7:0] count_q, count_d;
  logic [1:0] inhibit_q, inhibit_d;
  logic [5:0] opt_q, opt_d;
  logic       flag_q, flag_d;
  logic       ie_q, ie_d;
  logic       wdt_out_q, wdt_out_d;

  logic       clock_source_select;
  logic       edge_polarity_bit;
  logic       prescaler_assign_bit;
  logic [2:0] prescale_ratio_field;
  logic       cycle_end;
  logic       pin_edge;
  logic       src_tick;
  logic       psout;
  logic       inc_pulse;
  logic       overflow;

  assign clock_source_select  = opt_q[OPT_CS_BIT];
  assign edge_polarity_bit    = opt_q[OPT_SE_BIT];
  assign prescaler_assign_bit = opt_q[OPT_PSA_BIT];
  assign prescale_ratio_field = opt_q[OPT_PS_MSB:0];
  assign cycle_end            = (phase_q == TMZ_Q4);

  // divide tap: code n picks prescaler bit n, giving 2^(n+1)
  function automatic logic tap(input logic [7:0] p, input logic [2:0] r);
    tap = p[r];
  endfunction

  // phases two and four are the only points where the timer-side prescaler output psout is looked at
  function automatic logic smp_phase(input tmz_phase_t ph);
    smp_phase = (ph == TMZ_Q2) || (ph == TMZ_Q4);
  endfunction

  // =====================================================
  // next-state logic
  always_comb begin
    phase_d     = tmz_phase_t'(phase_q + 2'h1);
    pin_sync_d  = {pin_sync_q[0], external_count_pin};
    pin_prev_d  = pin_sync_q[1];
    // edge detect looks only at the second synchroniser stage
    pin_edge    = edge_polarity_bit ? (pin_prev_q & ~pin_sync_q[1])
                                    : (~pin_prev_q & pin_sync_q[1]);
    src_tick    = clock_source_select ? pin_edge : cycle_end;
    if (sleep_mode) begin
      src_tick = 1'b0;
    end
  end

  // =====================================================
  // prescaler and its output sampler
  always_comb begin
    // prescaler source: timer source or watchdog ticks
    presc_d = presc_q;
    if (prescaler_assign_bit ? watchdog_tick : src_tick) begin
      presc_d = presc_q + 8'h01;
    end
    if (count_we && !prescaler_assign_bit) begin
      presc_d = 8'h00;
    end
    if (clear_watchdog_instruction && prescaler_assign_bit) begin
      presc_d = 8'h00;
    end
    psout       = prescaler_assign_bit ? src_tick : tap(presc_q, prescale_ratio_field);
    wdt_out_d   = prescaler_assign_bit ? tap(presc_q, prescale_ratio_field) : watchdog_tick;
    // prescaled path samples on phase 2 and 4; unprescaled path counts the source tick directly
    psout_smp_d = psout_smp_q;
    if (smp_phase(phase_q)) begin
      psout_smp_d = psout;
    end
    if (prescaler_assign_bit) begin
      inc_pulse = src_tick;
    end else begin
      inc_pulse = psout & ~psout_smp_q & smp_phase(phase_q);
    end
  end

  // =====================================================
  // count register and its write hold-off
  // hold-off counts cycle ends, so a write late in a cycle still loses two full steps
  always_comb begin
    inhibit_d = inhibit_q;
    if (cycle_end && inhibit_q != 2'h0) begin
      inhibit_d = inhibit_q - 2'h1;
    end
    count_d  = count_q;
    overflow = 1'b0;
    if (count_we) begin
      count_d   = count_wdata;
      inhibit_d = INHIBIT_CYC;
    end else if (inc_pulse && inhibit_q == 2'h0 && !sleep_mode) begin
      count_d  = count_q + 8'h01;
      overflow = (count_q == COUNT_MAX);
    end
  end

  // =====================================================
  // option, enable and overflow flag
  always_comb begin
    opt_d = option_we ? option_wdata : opt_q;
    ie_d  = int_enable_we ? int_enable_wdata : ie_q;
    // set wins over a clear in the same cycle
    flag_d = flag_q;
    if (flag_clr) begin
      flag_d = 1'b0;
    end
    if (overflow || flag_set) begin
      flag_d = 1'b1;
    end
  end

  // =====================================================
  // registers: phase and pin front end
  // sync stages reset low: a pin held high at release reads as one rising edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_q     <= TMZ_Q1;
      pin_sync_q  <= 2'h0;
      pin_prev_q  <= 1'b0;
    end else begin
      phase_q     <= phase_d;
      pin_sync_q  <= pin_sync_d;
      pin_prev_q  <= pin_prev_d;
    end
  end

  // =====================================================
  // registers: prescaler
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_q     <= 8'h00;
      psout_smp_q <= 1'b0;
      wdt_out_q   <= 1'b0;
    end else begin
      presc_q     <= presc_d;
      psout_smp_q <= psout_smp_d;
      wdt_out_q   <= wdt_out_d;
    end
  end

  // =====================================================
  // registers: count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q     <= COUNT_ZERO;
      inhibit_q   <= 2'h0;
    end else begin
      count_q     <= count_d;
      inhibit_q   <= inhibit_d;
    end
  end

  // =====================================================
  // registers: control
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opt_q       <= OPT_RESET;
      flag_q      <= 1'b0;
      ie_q        <= 1'b0;
    end else begin
      opt_q       <= opt_d;
      flag_q      <= flag_d;
      ie_q        <= ie_d;
    end
  end

  // prescaler count itself is never brought out
  assign count_register          = count_q;
  assign option_bits             = opt_q;
  assign overflow_flag           = flag_q;
  assign overflow_int_enable     = ie_q;
  assign overflow_irq            = flag_q & ie_q;
  assign watchdog_prescaled_tick = wdt_out_q;
endmodule

/* tmz_pkg.sv */
// package of constants for the timer/counter with prescaler
package tmz_pkg;
  // =====================================================
  // option field positions, option reset value, count limits and write hold-off length
  localparam int unsigned OPT_CS_BIT   = 5;
  localparam int unsigned OPT_SE_BIT   = 4;
  localparam int unsigned OPT_PSA_BIT  = 3;
  localparam int unsigned OPT_PS_MSB   = 2;
  localparam logic [5:0]  OPT_RESET    = 6'h3f;
  localparam logic [7:0]  COUNT_MAX    = 8'hff;
  localparam logic [7:0]  COUNT_ZERO   = 8'h00;
  localparam logic [1:0]  INHIBIT_CYC  = 2'h2;
  // =====================================================
  // phase sequencer: four oscillator phases per instruction cycle
  typedef enum logic [1:0] {TMZ_Q1, TMZ_Q2, TMZ_Q3, TMZ_Q4} tmz_phase_t;
endpackage

/* tmz_pin_src.sv */
// model of the pulse source on the external count pin
`timescale 1ns/1ns
module tmz_pin_src (
  input  logic clk,
  input  logic want,
  output logic pin
);
  // ===========================================
  // pin level
  // lands between edges, as an unrelated source would; held many cycles, so widths are legal
  initial pin = 1'b0;
  always @(posedge clk) pin <= #37 want;
endmodule

/* tmz_timer0_assertions.sv */
// concurrent checks on the timer/counter ports
`timescale 1ns/1ns
module tmz_timer0_chk
  import tmz_pkg::*;
(
  input logic       clk,
  input logic       arst_n,
  input logic       sleep_mode,
  input logic       option_we,
  input logic [5:0] option_wdata,
  input logic       count_we,
  input logic [7:0] count_wdata,
  input logic       flag_clr,
  input logic [7:0] count_register,
  input logic [5:0] option_bits,
  input logic       overflow_flag,
  input logic       overflow_int_enable,
  input logic       overflow_irq
);
  // ===========================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // plain timer mode with nothing disturbing the count
  wire steady = option_bits == 6'h08 && !count_we && !option_we && !sleep_mode;
  sequence s_write;
    count_we ##1 (!count_we && !option_we && !option_bits[OPT_CS_BIT])[*4];
  endsequence
  sequence s_step;
    steady ##1 steady && count_register != $past(count_register) ##1 steady[*4];
  endsequence
  property p_rate; s_step |-> count_register == $past(count_register, 4) + 8'h01; endproperty
  a_rate: assert property (p_rate) else $error("timer step not four clocks");
  property p_hold_off; s_write |-> count_register == $past(count_register, 3); endproperty
  a_hold_off: assert property (p_hold_off) else $error("count moved after write");
  property p_ovf;
    !$past(count_we) && $past(count_register) == COUNT_MAX && count_register == COUNT_ZERO
      |-> overflow_flag;
  endproperty
  a_ovf: assert property (p_ovf) else $error("rollover without flag");
  property p_irq; overflow_irq == (overflow_flag && overflow_int_enable); endproperty
  a_irq: assert property (p_irq) else $error("request not flag and enable");
  property p_keep; overflow_flag && !flag_clr |=> overflow_flag; endproperty
  a_keep: assert property (p_keep) else $error("flag dropped on its own");
  property p_sleep; sleep_mode && !count_we |=> $stable(count_register); endproperty
  a_sleep: assert property (p_sleep) else $error("count moved in sleep");
  property p_load; count_we |=> count_register == $past(count_wdata); endproperty
  a_load: assert property (p_load) else $error("count write lost");
  property p_opt; option_we |=> option_bits == $past(option_wdata); endproperty
  a_opt: assert property (p_opt) else $error("option write lost");
  property p_reset; $rose(arst_n) |-> option_bits == OPT_RESET && !overflow_flag; endproperty
  a_reset: assert property (p_reset) else $error("bad reset values");
endmodule
bind tmz_timer0 tmz_timer0_chk u_chk (.*);

/* testbench.sv */
// self-checking bench for the timer/counter
`timescale 1ns/1ns
module testbench;
  // ===========================================
  // stimulus and design
  logic       clk = 1'b0, arst_n = 1'b0, slp = 1'b0, want = 1'b0, pin;
  logic       owe = 1'b0, cwe = 1'b0, clr = 1'b0, iwe = 1'b0, flg, ie, irq;
  logic       wdt = 1'b0, cwd = 1'b0, fs = 1'b0, ied = 1'b0, wpt;
  logic [5:0] od = 6'h00, opt;
  logic [7:0] cd = 8'h00, cnt;
  int         fails = 0, samples_checked = 0;
  always #50 clk = ~clk;
  tmz_pin_src src (.clk(clk), .want(want), .pin(pin));
  tmz_timer0 dut (.clk(clk), .arst_n(arst_n), .sleep_mode(slp), .external_count_pin(pin),
    .option_we(owe), .option_wdata(od), .count_we(cwe), .count_wdata(cd), .flag_clr(clr),
    .flag_set(fs), .int_enable_we(iwe), .int_enable_wdata(ied),
    .clear_watchdog_instruction(cwd), .watchdog_tick(wdt), .count_register(cnt),
    .option_bits(opt), .overflow_flag(flg), .overflow_int_enable(ie), .overflow_irq(irq),
    .watchdog_prescaled_tick(wpt));
  // ===========================================
  // tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // strobe k: 0 option, 1 count, 2 enable, 3 flag clear, 4 clear watchdog,
  // 5 watchdog tick, 6 flag set; ends settled at the negedge
  task automatic wr(input int k, input logic [7:0] v);
    @(posedge clk);
    od <= v[5:0];
    cd <= v;
    ied <= v[0];
    {fs, wdt, cwd, clr, iwe, cwe, owe} <= 7'h01 << k;
    @(posedge clk);
    {fs, wdt, cwd, clr, iwe, cwe, owe} <= 7'h00;
    @(negedge clk);
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // ===========================================
  // tests
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    w(0);
    chk({2'h0, opt}, 8'h3f);
    chk(cnt, 8'h00);
    wr(0, 8'h08);
    wr(1, 8'hfd);
    w(3);
    chk(cnt, 8'hfd);
    for (int i = 0; i < 40 && flg !== 1'b1; i++) w(0);
    chk({flg, irq, cnt[5:0]}, 8'h80);
    wr(2, 8'h01);
    chk({5'h00, flg, irq, ie}, 8'h07);
    wr(3, 8'h00);
    chk({7'h00, flg}, 8'h00);
    @(posedge clk) slp <= 1'b1;
    wr(1, 8'h40);
    w(40);
    chk(cnt, 8'h40);
    @(posedge clk) slp <= 1'b0;
    w(20);
    chk({7'h00, cnt > 8'h40}, 8'h01);
    // window of 5.5 prescaled periods absorbs the hold-off and the phase jitter
    for (int n = 0; n < 8; n++) begin
      wr(0, 8'(n));
      wr(1, 8'h00);
      w(44 << n);
      chk({7'h00, cnt === 8'h04 || cnt === 8'h05}, 8'h01);
    end
    for (int e = 0; e < 2; e++) begin
      wr(0, e ? 8'h38 : 8'h28);
      wr(1, 8'h00);
      w(12);
      @(posedge clk) want <= 1'b1;
      w(12);
      chk(cnt, 8'(1 - e));
      @(posedge clk) want <= 1'b0;
      w(12);
      chk(cnt, 8'h01);
    end
    // prescaler on the watchdog side, ratio code zero
    wr(4, 8'h00);
    w(1);
    chk({7'h00, wpt}, 8'h00);
    wr(5, 8'h00);
    w(1);
    chk({7'h00, wpt}, 8'h01);
    wr(4, 8'h00);
    w(1);
    chk({7'h00, wpt}, 8'h00);
    // prescaler back on the timer: watchdog ticks pass straight through
    wr(0, 8'h20);
    wr(5, 8'h00);
    chk({7'h00, wpt}, 8'h01);
    w(1);
    chk({7'h00, wpt}, 8'h00);
    wr(2, 8'h00);
    wr(6, 8'h00);
    chk({6'h00, flg, irq}, 8'h02);
    wr(3, 8'h00);
    chk({7'h00, flg}, 8'h00);
    test_done();
  end
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule
